// File: hdl/acp_pkg.sv
package acp_pkg;
    // ==================================================
    // Cell layout
    localparam int CELL_LEN = 53;
    localparam int PAY_LEN = 48;
    localparam logic [5:0] HDR_LAST = 6'h04;
    localparam logic [5:0] CELL_LAST = 6'h34;
    localparam logic [5:0] PAY_FIRST = 6'h05;
    // ==================================================
    // Header check sequence and idle cell
    localparam logic [7:0] HCS_POLY = 8'h07;
    localparam logic [7:0] HCS_COSET = 8'h55;
    localparam logic [31:0] IDLE_HDR = 32'h00000001;
    localparam logic [7:0] IDLE_PAY = 8'h6A;
    // ==================================================
    // Delineation thresholds
    localparam logic [2:0] DELIN_DELTA = 3'h6;
    localparam logic [2:0] DELIN_ALPHA = 3'h7;
    // ==================================================
    // APB register offsets
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STAT = 8'h04;
    localparam logic [7:0] REG_UNCORR = 8'h08;
    localparam logic [7:0] REG_CORR = 8'h0C;
    localparam logic [7:0] REG_PASSED = 8'h10;
    // Control fields
    localparam int CTRL_DESC = 0;
    localparam int CTRL_SCR = 1;
    localparam int CTRL_DROP = 2;
    localparam int CTRL_GFC = 3;
    localparam int CTRL_DEPTH = 4;
    localparam logic [7:0] CTRL_RESET = 8'h3F;
    // Status fields
    localparam int STAT_LCD = 3;
    localparam int STAT_PARERR = 4;

    typedef enum logic [2:0] {
        ACP_HUNT = 3'b001,
        ACP_PRESYNC = 3'b010,
        ACP_SYNC = 3'b100
    } acp_delin_type;

    // CRC-8 over a four-octet header, no coset
    function automatic logic [7:0] acp_crc(input logic [31:0] h);
        logic [7:0] c;
        logic fb;
        c = 8'h00;
        for (int i = 31; i >= 0; i--) begin
            fb = c[7] ^ h[i];
            c = {c[6:0], 1'b0};
            if (fb) begin
                c = c ^ HCS_POLY;
            end
        end
        return c;
    endfunction

    // Self-synchronous x^43+1 step over one byte, returns {state, byte}
    function automatic logic [50:0] acp_scr(input logic [42:0] s, input logic [7:0] d, input logic desc);
        logic [7:0] o;
        o = 8'h00;
        for (int i = 7; i >= 0; i--) begin
            o[i] = d[i] ^ s[42];
            s = {s[41:0], desc ? d[i] : o[i]};
        end
        return {s, o};
    endfunction

    // Byte i of a five-octet header
    function automatic logic [7:0] acp_hbyte(input logic [39:0] h, input logic [5:0] i);
        case (i)
            6'h00: return h[39:32];
            6'h01: return h[31:24];
            6'h02: return h[23:16];
            6'h03: return h[15:8];
            default: return h[7:0];
        endcase
    endfunction
endpackage

// File: hdl/acp_top.sv
// Functional notes
// - Delineate cells before any cell processing
// - Flag loss of cell delineation alarm
// - Check HCS and correct correctable headers
// - Drop uncorrectable headers, never buffer them
// - Filter idle or unassigned cells when enabled
// - Optional descrambling of receive payload
// - Serial GFC out from error-free cells only
// - Passed cells go into four-cell buffer
// - Byte-wide synchronous cell-based read handshake
// - Count uncorrectable, corrected and passed cells
// - Parity travels with buffered cell bytes; code stores none, checks it on write, regenerates it on read
// - Byte-wide writes into programmable-depth buffer
// - Idle cell when no cell or hold
// - Hold suspends user cells regardless of fill
// - GFC inserted after the transmit buffer
// - Generate HCS for every outgoing header
// - Scramble transmit payload unless disabled
// - Cell boundary offset given on H4 output
//
// Added by the designer: the address map and the APB interface to the registers.
`timescale 1ns/10ps
module acp_top import acp_pkg::*; #(
    parameter int CELLS = 4,
    parameter int CNT_W = 16
) (
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_reset_n,
    // APB slave
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    // Receive payload from SPE
    input wire logic i_rx_valid,
    input wire logic [7:0] i_rx_data,
    output logic o_lcd,
    // Receive cell read port
    input wire logic i_rx_rd_en,
    output logic o_rx_cell_avail,
    output logic o_rx_valid,
    output logic o_rx_soc,
    output logic [7:0] o_rx_data,
    output logic o_rx_par,
    // Receive GFC serial port
    output logic o_rx_gfc,
    output logic o_rx_gfc_valid,
    // Transmit cell write port
    input wire logic i_tx_wr_en,
    input wire logic i_tx_soc,
    input wire logic [7:0] i_tx_data,
    input wire logic i_tx_par,
    output logic o_tx_room,
    input wire logic i_transmit_hold,
    // Transmit GFC serial port
    input wire logic i_tx_gfc_valid,
    input wire logic i_tx_gfc,
    // Transmit SPE byte stream
    input wire logic i_tx_take,
    output logic [7:0] o_tx_data,
    output logic o_tx_soc,
    output logic [7:0] o_tx_h4
);
    localparam int SW = $clog2(CELLS);
    localparam int CW = $clog2(CELLS + 1);

    // ==================================================
    // Reset release
    logic [1:0] rst_q;
    logic rst_n;
    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            rst_q <= 2'h0;
        end else begin
            rst_q <= {rst_q[0], 1'b1};
        end
    end
    assign rst_n = rst_q[1];

    // ==================================================
    // Register file
    logic [7:0] ctrl;
    logic par_err;
    logic [CNT_W-1:0] cnt_unc, cnt_cor, cnt_pass;
    acp_delin_type state;
    logic apb_wr;
    assign apb_wr = i_psel & i_penable & i_pwrite;
    assign o_pready = 1'b1;

    // Control register write
    always_ff @(posedge i_clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ctrl <= CTRL_RESET;
        end else if (apb_wr && i_paddr == REG_CTRL) begin
            ctrl <= i_pwdata[7:0];
        end
    end

    // Read mux, unmapped offsets answer with error
    always_comb begin
        o_prdata = 32'h00000000;
        o_pslverr = 1'b0;
        case (i_paddr)
            REG_CTRL: o_prdata = {24'h000000, ctrl};
            REG_STAT: o_prdata = {27'h0000000, par_err, o_lcd, state};
            REG_UNCORR: o_prdata = 32'(cnt_unc);
            REG_CORR: o_prdata = 32'(cnt_cor);
            REG_PASSED: o_prdata = 32'(cnt_pass);
            default: o_pslverr = i_psel & i_penable;
        endcase
    end

    // ==================================================
    // Receive delineation and HCS
    logic [39:0] win, win_n;
    logic [5:0] bidx;
    logic [2:0] gcnt, bcnt;
    logic [7:0] syn;
    logic [31:0] fix;
    logic fixable, hunt_hit, hdr_end, accept, is_idle, keep, commit;
    logic [SW-1:0] rw_slot, rr_slot;
    logic [CW-1:0] rx_cnt;
    logic [39:0] rhdr [0:CELLS-1];
    logic [7:0] rpay [0:CELLS-1][0:PAY_LEN-1];
    logic [42:0] dsc, dsc_n;
    logic [7:0] dpay;

    // Syndrome and single-bit correction mask
    // CRC-8 with coset
    always_comb begin
        win_n = {win[31:0], i_rx_data};
        syn = acp_crc(win_n[39:8]) ^ HCS_COSET ^ win_n[7:0];
        fix = 32'h00000000;
        for (int i = 0; i < 32; i++) begin
            if (syn != 8'h00 && acp_crc(32'h00000001 << i) == syn) begin
                fix[i] = 1'b1;
            end
        end
    end
    assign fixable = (syn == 8'h00) || (fix != 32'h00000000) || $onehot(syn);
    assign hunt_hit = i_rx_valid && state == ACP_HUNT && syn == 8'h00;
    assign hdr_end = i_rx_valid && state != ACP_HUNT && bidx == HDR_LAST;
    assign is_idle = (win_n[35:12] ^ fix[27:4]) == 24'h000000;
    // only fixable headers, in sync, with room
    assign accept = hdr_end && state == ACP_SYNC && fixable && !(ctrl[CTRL_DROP] && is_idle)
                    && rx_cnt < CW'(CELLS);
    assign commit = keep && i_rx_valid && bidx == CELL_LAST;

    // Byte window
    always_ff @(posedge i_clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            win <= 40'h0000000000;
        end else if (i_rx_valid) begin
            win <= win_n;
        end
    end

    always_ff @(posedge i_clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state <= ACP_HUNT;
            bidx <= 6'h00;
            gcnt <= 3'h0;
            bcnt <= 3'h0;
        end else if (hunt_hit) begin
            state <= ACP_PRESYNC;
            bidx <= PAY_FIRST;
            gcnt <= 3'h0;
            bcnt <= 3'h0;
        end else if (i_rx_valid && state != ACP_HUNT) begin
            bidx <= (bidx == CELL_LAST) ? 6'h00 : bidx + 6'h01;
            if (hdr_end) begin
                case (state)
                    ACP_PRESYNC: begin
                        if (syn != 8'h00) begin
                            state <= ACP_HUNT;
                        end else if (gcnt == DELIN_DELTA - 3'h1) begin
                            state <= ACP_SYNC;
                        end else begin
                            gcnt <= gcnt + 3'h1;
                        end
                    end
                    ACP_SYNC: begin
                        if (syn == 8'h00) begin
                            bcnt <= 3'h0;
                        end else if (bcnt == DELIN_ALPHA - 3'h1) begin
                            state <= ACP_HUNT;
                        end else begin
                            bcnt <= bcnt + 3'h1;
                        end
                    end
                    default: state <= ACP_HUNT;
                endcase
            end
        end
    end

    always_ff @(posedge i_clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            o_lcd <= 1'b1;
        end else begin
            o_lcd <= state != ACP_SYNC;
        end
    end

    always_comb begin
        {dsc_n, dpay} = acp_scr(dsc, i_rx_data, 1'b1);
    end
    always_ff @(posedge i_clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            dsc <= 43'h0;
        end else if (i_rx_valid && state != ACP_HUNT && bidx >= PAY_FIRST) begin
            dsc <= dsc_n;
        end
    end

    // cell storage, committed only when complete
    always_ff @(posedge i_clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            keep <= 1'b0;
            rw_slot <= '0;
        end else begin
            if (hdr_end || hunt_hit) begin
                keep <= accept;
            end else if (commit) begin
                keep <= 1'b0;
                rw_slot <= rw_slot + SW'(1);
            end
        end
    end
    always_ff @(posedge i_clk_sys) begin
        if (accept) begin
            rhdr[rw_slot] <= {win_n[39:8] ^ fix, acp_crc(win_n[39:8] ^ fix) ^ HCS_COSET};
        end
        if (keep && i_rx_valid && bidx >= PAY_FIRST) begin
            rpay[rw_slot][bidx - PAY_FIRST] <= ctrl[CTRL_DESC] ? dpay : i_rx_data;
        end
    end

    always_ff @(posedge i_clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cnt_unc <= '0;
            cnt_cor <= '0;
            cnt_pass <= '0;
        end else begin
            if (hdr_end && state == ACP_SYNC && !fixable) begin
                cnt_unc <= cnt_unc + CNT_W'(1);
            end
            if (accept && syn != 8'h00) begin
                cnt_cor <= cnt_cor + CNT_W'(1);
            end
            if (commit) begin
                cnt_pass <= cnt_pass + CNT_W'(1);
            end
        end
    end

    // GFC shifted out from error-free headers
    logic [3:0] gfc_sr;
    logic [2:0] gfc_left;
    always_ff @(posedge i_clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            gfc_sr <= 4'h0;
            gfc_left <= 3'h0;
            o_rx_gfc <= 1'b0;
            o_rx_gfc_valid <= 1'b0;
        end else if (hdr_end && state == ACP_SYNC && syn == 8'h00) begin
            gfc_sr <= win_n[39:36];
            gfc_left <= 3'h4;
            o_rx_gfc_valid <= 1'b0;
        end else if (gfc_left != 3'h0) begin
            o_rx_gfc <= gfc_sr[3];
            o_rx_gfc_valid <= 1'b1;
            gfc_sr <= {gfc_sr[2:0], 1'b0};
            gfc_left <= gfc_left - 3'h1;
        end else begin
            o_rx_gfc_valid <= 1'b0;
        end
    end

    // ==================================================
    // Receive read port
    logic [5:0] ridx;
    logic [7:0] rbyte;
    logic rd_go, rd_last;
    assign o_rx_cell_avail = rx_cnt != '0;
    assign rd_go = i_rx_rd_en && rx_cnt != '0;
    assign rd_last = rd_go && ridx == CELL_LAST;
    assign rbyte = (ridx <= HDR_LAST) ? acp_hbyte(rhdr[rr_slot], ridx) : rpay[rr_slot][ridx - PAY_FIRST];

    always_ff @(posedge i_clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ridx <= 6'h00;
            rr_slot <= '0;
            o_rx_valid <= 1'b0;
            o_rx_soc <= 1'b0;
            o_rx_data <= 8'h00;
            o_rx_par <= 1'b0;
        end else begin
            o_rx_valid <= rd_go;
            o_rx_soc <= rd_go && ridx == 6'h00;
            if (rd_go) begin
                o_rx_data <= rbyte;
                o_rx_par <= ^rbyte;
                ridx <= rd_last ? 6'h00 : ridx + 6'h01;
                rr_slot <= rd_last ? rr_slot + SW'(1) : rr_slot;
            end
        end
    end

    // Receive fill count
    always_ff @(posedge i_clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rx_cnt <= '0;
        end else begin
            rx_cnt <= rx_cnt + CW'(commit) - CW'(rd_last);
        end
    end

    // ==================================================
    // Transmit buffer write side
    logic [31:0] thdr [0:CELLS-1];
    logic [7:0] tpay [0:CELLS-1][0:PAY_LEN-1];
    logic [5:0] widx, wi;
    logic [SW-1:0] tw_slot, tr_slot;
    logic [CW-1:0] tx_cnt, depth;
    logic wdrop, tx_commit, tx_done;
    assign depth = CW'(ctrl[CTRL_DEPTH +: 2]) + CW'(1);
    // room only up to programmed depth
    assign o_tx_room = tx_cnt < depth;
    assign wi = i_tx_soc ? 6'h00 : widx;
    assign tx_commit = i_tx_wr_en && wi == CELL_LAST && !(wdrop && wi != 6'h00);

    always_ff @(posedge i_clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            widx <= 6'h00;
            wdrop <= 1'b0;
            tw_slot <= '0;
        end else if (i_tx_wr_en) begin
            widx <= (wi == CELL_LAST) ? 6'h00 : wi + 6'h01;
            if (wi == 6'h00) begin
                wdrop <= !o_tx_room;
            end
            if (tx_commit) begin
                tw_slot <= tw_slot + SW'(1);
            end
        end
    end
    always_ff @(posedge i_clk_sys) begin
        if (i_tx_wr_en && (wi == 6'h00 ? o_tx_room : !wdrop)) begin
            if (wi < HDR_LAST) begin
                thdr[tw_slot][{~wi[1:0], 3'b000} +: 8] <= i_tx_data;
            end else if (wi >= PAY_FIRST) begin
                tpay[tw_slot][wi - PAY_FIRST] <= i_tx_data;
            end
        end
    end

    // sticky parity error, set wins over clear
    always_ff @(posedge i_clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            par_err <= 1'b0;
        end else if (i_tx_wr_en && (^i_tx_data) != i_tx_par) begin
            par_err <= 1'b1;
        end else if (apb_wr && i_paddr == REG_STAT && i_pwdata[STAT_PARERR]) begin
            par_err <= 1'b0;
        end
    end

    // ==================================================
    // Transmit cell generator
    logic [5:0] oidx;
    logic [31:0] cur_hdr, nhdr;
    logic cur_user, nuser;
    logic [3:0] tgfc;
    logic [42:0] scr, scr_n;
    logic [7:0] praw, pscr, tbyte;

    always_ff @(posedge i_clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            tgfc <= 4'h0;
        end else if (i_tx_gfc_valid) begin
            tgfc <= {tgfc[2:0], i_tx_gfc};
        end
    end

    always_comb begin
        nuser = tx_cnt != '0 && !i_transmit_hold;
        nhdr = nuser ? thdr[tr_slot] : IDLE_HDR;
        if (nuser && ctrl[CTRL_GFC]) begin
            nhdr[31:28] = tgfc;
        end
    end

    always_comb begin
        praw = cur_user ? tpay[tr_slot][oidx - PAY_FIRST] : IDLE_PAY;
        {scr_n, pscr} = acp_scr(scr, praw, 1'b0);
        if (oidx == 6'h00) begin
            tbyte = nhdr[31:24];
        end else if (oidx < HDR_LAST) begin
            tbyte = acp_hbyte({cur_hdr, 8'h00}, oidx);
        end else if (oidx == HDR_LAST) begin
            tbyte = acp_crc(cur_hdr) ^ HCS_COSET;
        end else begin
            tbyte = ctrl[CTRL_SCR] ? pscr : praw;
        end
    end
    assign tx_done = i_tx_take && oidx == CELL_LAST && cur_user;

    always_ff @(posedge i_clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            oidx <= 6'h00;
            cur_hdr <= IDLE_HDR;
            cur_user <= 1'b0;
            tr_slot <= '0;
            scr <= 43'h0;
            o_tx_data <= 8'h00;
            o_tx_soc <= 1'b0;
            o_tx_h4 <= 8'h00;
        end else if (i_tx_take) begin
            o_tx_data <= tbyte;
            o_tx_soc <= oidx == 6'h00;
            o_tx_h4 <= (oidx == 6'h00) ? 8'h00 : 8'(CELL_LEN) - {2'b00, oidx};
            oidx <= (oidx == CELL_LAST) ? 6'h00 : oidx + 6'h01;
            if (oidx == 6'h00) begin
                cur_hdr <= nhdr;
                cur_user <= nuser;
            end
            if (oidx >= PAY_FIRST) begin
                scr <= scr_n;
            end
            if (tx_done) begin
                tr_slot <= tr_slot + SW'(1);
            end
        end
    end

    // Transmit fill count
    always_ff @(posedge i_clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            tx_cnt <= '0;
        end else begin
            tx_cnt <= tx_cnt + CW'(tx_commit) - CW'(tx_done);
        end
    end

    // ==================================================
    // Assertions
    default clocking acp_cb @(posedge i_clk_sys); endclocking
    default disable iff (!rst_n);

    AST_HUNT_LOCK: assert property (hunt_hit |=> state == ACP_PRESYNC && bidx == PAY_FIRST)
        else $error("hunt hit did not enter presync");
    AST_LCD_FLAG: assert property (state == ACP_SYNC |=> !o_lcd)
        else $error("alarm raised while in sync");
    AST_UNC_COUNT: assert property (hdr_end && state == ACP_SYNC && !fixable |=> cnt_unc == $past(cnt_unc) + CNT_W'(1))
        else $error("uncorrectable count missed");
    AST_NO_BAD_KEEP: assert property (hdr_end && !fixable |=> !keep)
        else $error("bad header cell kept");
    AST_RX_DEPTH: assert property (rx_cnt <= CW'(CELLS))
        else $error("receive buffer overfilled");
    AST_RX_SOC: assert property (rd_go && ridx == 6'h00 |=> o_rx_soc && o_rx_valid)
        else $error("start of cell not flagged");
    AST_GFC_OUT: assert property (hdr_end && state == ACP_SYNC && syn == 8'h00 |=> ##1 o_rx_gfc_valid [*4] ##1 !o_rx_gfc_valid)
        else $error("gfc serial burst wrong");
    AST_HOLD_IDLE: assert property (i_tx_take && oidx == 6'h00 && i_transmit_hold |=> !cur_user && o_tx_data == IDLE_HDR[31:24])
        else $error("user cell sent under hold");
    AST_TX_HCS: assert property (i_tx_take && oidx == HDR_LAST |=> o_tx_data == (acp_crc(cur_hdr) ^ HCS_COSET))
        else $error("transmit hcs wrong");
    AST_TX_DEPTH: assert property (i_tx_wr_en && wi == 6'h00 && !o_tx_room |=> wdrop)
        else $error("cell accepted beyond depth");

    COV_SYNC: cover property ($rose(state == ACP_SYNC));
    COV_CORR: cover property (accept && syn != 8'h00);
    COV_RX_CELL: cover property (rd_last);
    COV_TX_USER: cover property (tx_done);
endmodule

// File: dv/acp_atm_model.sv
`timescale 1ns/10ps
// ==========
// Drop side reader with random stalls
module acp_atm_model (
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_reset_n,
    // Receive read port
    input wire logic i_cell_avail,
    output logic o_rd_en
);
    logic [15:0] lfsr;
    // read only when a cell was waiting at the previous clock edge
    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            lfsr <= 16'hACE1;
            o_rd_en <= 1'b0;
        end else begin
            lfsr <= {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
            o_rd_en <= i_cell_avail & lfsr[0];
        end
    end
endmodule

// File: dv/test_atm_cell_processor.sv
`timescale 1ns/10ps
module test_atm_cell_processor import acp_pkg::*; ;
    // ==========
    // Stimulus and design
    logic clk = 0, rst_n = 0, psel = 0, pen = 0, pwr = 0, rxv = 0, txw = 0, txs = 0, txp = 0, hold = 0, gv = 0;
    logic [7:0] paddr = 0, rxd = 0, txd = 0;
    logic [31:0] pwd = 0, r;
    logic e, rd_en, avail, rx_valid, rx_soc, rx_par, tx_soc, room, lcd, pready, pslverr, gfc, gfcv;
    logic [7:0] rx_data, tx_data, tx_h4;
    logic [31:0] prdata;
    logic [15:0] xs = 16'hB586;
    logic [7:0] cc [53];
    logic [7:0] oc [53];
    logic [9:0] exp_q [$];
    int errors = 0, total_checks = 0, cyc = 0, n, gfc_bits = 0, gfc_ones = 0;
    acp_top acp_top_i (.i_clk_sys(clk), .i_reset_n(rst_n), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
        .i_paddr(paddr), .i_pwdata(pwd), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
        .i_rx_valid(rxv), .i_rx_data(rxd), .o_lcd(lcd), .i_rx_rd_en(rd_en), .o_rx_cell_avail(avail),
        .o_rx_valid(rx_valid), .o_rx_soc(rx_soc), .o_rx_data(rx_data), .o_rx_par(rx_par), .o_rx_gfc(gfc),
        .o_rx_gfc_valid(gfcv), .i_tx_wr_en(txw), .i_tx_soc(txs), .i_tx_data(txd), .i_tx_par(txp),
        .o_tx_room(room), .i_transmit_hold(hold), .i_tx_gfc_valid(gv), .i_tx_gfc(gv),
        .i_tx_take(1'b1), .o_tx_data(tx_data), .o_tx_soc(tx_soc), .o_tx_h4(tx_h4));
    acp_atm_model acp_atm_model_i (.i_clk_sys(clk), .i_reset_n(rst_n), .i_cell_avail(avail), .o_rd_en(rd_en));
    // Clock
    initial begin
        forever #12.5 clk = ~clk;
    end
    // ==========
    // Helpers
    function automatic logic [7:0] rnd8();
        xs = xs ^ (xs << 7);
        xs = xs ^ (xs >> 9);
        xs = xs ^ (xs << 8);
        return xs[7:0];
    endfunction
    function automatic logic [7:0] hcs(input logic [31:0] h);
        logic [7:0] c;
        c = 8'h00;
        for (int i = 31; i >= 0; i--) c = {c[6:0], 1'b0} ^ ((c[7] ^ h[i]) ? HCS_POLY : 8'h00);
        return c ^ HCS_COSET;
    endfunction
    task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
        total_checks++;
        if (g !== x) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, x, g);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1;
        pwr <= w;
        paddr <= a;
        pwd <= d;
        @(posedge clk);
        pen <= 1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 0;
        pen <= 0;
        // Idle edge so the next call never re-drives psel in this step
        @(posedge clk);
    endtask
    // Sends h and code; a kept cell is expected back with header g
    task automatic rx_cell(input logic [31:0] h, input logic [7:0] hc, input logic [31:0] g, input bit keep);
        logic [7:0] b;
        for (int i = 0; i < 53; i++) begin
            b = i < 4 ? h[31 - 8 * i -: 8] : (i == 4 ? hc : rnd8());
            rxv <= 1;
            rxd <= b;
            if (keep) exp_q.push_back({i == 0, ^(i < 4 ? g[31 - 8 * i -: 8] : (i == 4 ? hcs(g) : b)),
                i < 4 ? g[31 - 8 * i -: 8] : (i == 4 ? hcs(g) : b)});
            @(posedge clk);
        end
        rxv <= 0;
        @(posedge clk);
    endtask
    task automatic tx_write();
        for (int i = 0; i < 53; i++) begin
            txw <= 1;
            txs <= i == 0;
            txd <= cc[i];
            txp <= ^cc[i];
            @(posedge clk);
        end
        txw <= 0;
        txs <= 0;
        @(posedge clk);
    endtask
    task automatic tx_cell();
        n = 0;
        @(posedge clk);
        while (tx_soc !== 1'b1 && n < 300) begin
            @(posedge clk);
            n++;
        end
        chk("tx soc seen", 1, tx_soc);
        chk("h4 at soc", 0, tx_h4);
        for (int i = 0; i < 53; i++) begin
            oc[i] = tx_data;
            @(posedge clk);
        end
    endtask
    // ==========
    // Receive monitor
    always @(posedge clk) begin
        if (rx_valid === 1'b1) begin
            if (exp_q.size() == 0) chk("rx extra byte", 0, 1);
            else chk("rx byte", exp_q.pop_front(), {rx_soc, rx_par, rx_data});
        end
        // Tally serial GFC bits
        if (gfcv === 1'b1) begin
            gfc_bits++;
            if (gfc === 1'b1) gfc_ones++;
        end
    end
    // Timeout
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            errors++;
            tally_and_finish();
        end
    end
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // ==========
    // Main sequence
    initial begin
        repeat (10) @(posedge clk);
        rst_n <= 1;
        repeat (3) @(posedge clk);
        apb(0, REG_CTRL, 0);
        chk("ctrl reset", 32'h3F, r);
        for (int a = 8; a <= 16; a += 4) begin
            apb(0, a, 0);
            chk("counter reset", 0, r);
        end
        apb(0, 8'h14, 0);
        chk("unmapped err", 1, e);
        chk("lcd at reset", 1, lcd);
        $display("test registers done");
        apb(1, REG_CTRL, 32'h3C);
        for (int k = 0; k < 10; k++) rx_cell(IDLE_HDR, hcs(IDLE_HDR), 0, 0);
        chk("lcd in sync", 0, lcd);
        apb(0, REG_STAT, 0);
        chk("state sync", 4, r[2:0]);
        rx_cell(32'h0A123450, hcs(32'h0A123450), 32'h0A123450, 1);
        rx_cell(IDLE_HDR, hcs(IDLE_HDR), 0, 0);
        rx_cell(32'hFB223460 ^ 32'h100, hcs(32'hFB223460), 32'hFB223460, 1);
        rx_cell(32'h0C323470 ^ 32'h1100, hcs(32'h0C323470), 0, 0);
        rx_cell(32'hFD423480, hcs(32'hFD423480), 32'hFD423480, 1);
        n = 0;
        while (exp_q.size() != 0 && n < 3000) begin
            @(posedge clk);
            n++;
        end
        chk("rx drained", 0, exp_q.size());
        // Six clean headers in sync; only the last user cell has GFC ones
        chk("gfc ones", 4, gfc_ones);
        chk("gfc bits", 4 * (12 - DELIN_DELTA), gfc_bits);
        for (int a = 8; a <= 16; a += 4) begin
            apb(0, a, 0);
            chk("counter", a == 16 ? 3 : 1, r);
        end
        for (int k = 0; k < 8; k++) rx_cell(32'h0A123450, hcs(32'h0A123450) ^ 8'h03, 0, 0);
        chk("lcd after loss", 1, lcd);
        $display("test receive done");
        hold <= 1;
        gv <= 1;
        for (int i = 0; i < 53; i++) cc[i] = i < 4 ? 8'h10 + i : rnd8();
        chk("room empty", 1, room);
        for (int k = 0; k < 5; k++) tx_write();
        @(posedge clk);
        chk("room full", 0, room);
        for (int k = 0; k < 2; k++) begin
            tx_cell();
            chk("idle hdr", IDLE_HDR, {oc[0], oc[1], oc[2], oc[3]});
            chk("idle hcs", hcs(IDLE_HDR), oc[4]);
            chk("idle pay", IDLE_PAY, oc[30]);
        end
        hold <= 0;
        for (int k = 0; k < 3 && oc[0] !== 8'hF0; k++) tx_cell();
        for (int i = 0; i < 53; i++) begin
            chk("tx byte", i == 0 ? 8'hF0 : (i == 4 ? hcs(32'hF0111213) : cc[i]), oc[i]);
        end
        $display("test transmit done");
        tally_and_finish();
    end
endmodule
